// ==== verilog/ncs_pkg.sv ====
// Package: register map, field layout and bus types for notch staging
package ncs_pkg;

  // ==========================================================
  // Register indices (printed offsets are not multiples of 4)
  localparam logic [7:0] IDX_NOTCH0 = 8'h1B;
  localparam logic [7:0] IDX_NOTCH1 = 8'h1C;
  localparam logic [7:0] IDX_NOTCH2 = 8'h1D;
  localparam logic [7:0] IDX_NOTCH3 = 8'h1E;
  localparam logic [7:0] IDX_STATUS = 8'h1F;

  // ==========================================================
  // Field layout
  localparam int REG_W     = 9;
  localparam int COMMIT_B  = 8;
  localparam int FILT_ON_B = 7;
  localparam int HALF_W    = 7;
  localparam int COEF_W    = 14;
  localparam int NREG      = 4;

  // ==========================================================
  // Reset values and bus response codes
  localparam logic [8:0] NOTCH_RST = 9'h000;
  localparam logic [1:0] BUS_OK    = 2'h0;
  localparam logic [1:0] BUS_SLVER = 2'h2;

  // ==========================================================
  // Bus carrier
  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
  } ncs_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic        readdatavalid;
    logic [1:0]  response;
    logic [31:0] readdata;
  } ncs_rsp_t;

  // Active filter settings
  typedef struct packed {
    logic              filterOn;
    logic [COEF_W-1:0] coefZero;
    logic [COEF_W-1:0] coefOne;
  } ncs_cfg_t;

  // Byte address to register index
  function automatic logic [7:0] ncs_index(input logic [9:0] addr);
    return addr[9:2];
  endfunction

endpackage

// ==== verilog/ncs_avalon_slave.sv ====
// Avalon-MM slave front end: one wait cycle, then access strobe
`timescale 1ns/1ps
module ncs_avalon_slave (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           rst_b,
  // Bus request
  input  wire ncs_pkg::ncs_req_t req,
  output logic                waitrequest,
  // Decoded access, one-cycle strobes
  output logic                accWr,
  output logic                accRd
);

  logic busy_reg;

  // First request cycle stalls; second cycle completes it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= req.read | req.write;
    end
  end

  // Low only on the completing cycle; a flop, so no glitch reaches pins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else if (busy_reg) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(req.read | req.write);
    end
  end

  // Strobes valid only on the completing cycle
  assign accWr       = busy_reg & req.write;
  assign accRd       = busy_reg & req.read;

endmodule

// ==== verilog/ncs_stage_reg.sv ====
// One staged notch register: staged word only; the pending flag is kept in the bank
`timescale 1ns/1ps
module ncs_stage_reg (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Write of this register
  input  wire logic       wrHit,
  input  wire logic [8:0] wrData,
  // Global commit strobe
  input  wire logic       commit,
  // Staged word, commit bit stripped
  output logic [7:0]      stagedVal
);

  logic [7:0] staged_reg;

  // Commit bit is never kept
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      staged_reg <= ncs_pkg::NOTCH_RST[7:0];
    end else if (wrHit) begin
      staged_reg <= wrData[7:0];
    end
  end

  assign stagedVal = staged_reg;

  // Commit handled by the bank; input kept for symmetry of timing
  logic unusedCommit;
  assign unusedCommit = commit;

endmodule

// ==== verilog/ncs_notch_bank.sv ====
// Notch filter coefficient staging bank, Avalon-MM register slave
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module ncs_notch_bank (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Avalon-MM slave
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [9:0]        address,
  input  wire logic [31:0]       writedata,
  output logic                   waitrequest,
  output logic [31:0]            readdata,
  output logic [1:0]             response,
  // Active filter settings
  output ncs_pkg::ncs_cfg_t      activeCfg,
  output logic                   commitPulse
);

  // ==========================================================
  // Bus front end
  ncs_pkg::ncs_req_t req;
  logic              accWr;
  logic              waitInt;
  logic              accStart;

  assign req.read      = read;
  assign req.write     = write;
  assign req.address   = address;
  assign req.writedata = writedata;

  ncs_avalon_slave u_slave (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .req         (req),
    .waitrequest (waitInt),
    .accWr       (accWr),
    .accRd       ()
  );

  // Waitrequest comes straight from the slave's flop; high in reset
  assign waitrequest = waitInt;

  // Request seen while idle: high through the single wait cycle, which ends at the next edge
  assign accStart = waitInt & (read | write);

  // ==========================================================
  // Decode
  logic [7:0] idx;
  logic [3:0] wrHit;
  logic       mapped;
  logic       commitReq;

  assign idx = ncs_pkg::ncs_index(address);

  always_comb begin
    wrHit[0] = accWr && (idx == ncs_pkg::IDX_NOTCH0);
    wrHit[1] = accWr && (idx == ncs_pkg::IDX_NOTCH1);
    wrHit[2] = accWr && (idx == ncs_pkg::IDX_NOTCH2);
    wrHit[3] = accWr && (idx == ncs_pkg::IDX_NOTCH3);
    mapped   = (idx >= ncs_pkg::IDX_NOTCH0) &&
               (idx <= ncs_pkg::IDX_STATUS);
  end

  // Any notch write with bit 8 set commits all four
  assign commitReq = (|wrHit) && writedata[ncs_pkg::COMMIT_B];

  // ==========================================================
  // Staging registers
  logic [7:0] staged [ncs_pkg::NREG];

  genvar g;
  generate
    for (g = 0; g < ncs_pkg::NREG; g++) begin : gStage
      ncs_stage_reg u_stage (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .wrHit     (wrHit[g]),
        .wrData    (writedata[8:0]),
        .commit    (commitReq),
        .stagedVal (staged[g])
      );
    end
  endgenerate

  // ==========================================================
  // Merged view: the word being written this cycle wins
  logic [7:0] merged [ncs_pkg::NREG];

  always_comb begin
    for (int i = 0; i < ncs_pkg::NREG; i++) begin
      merged[i] = wrHit[i] ? writedata[7:0] : staged[i];
    end
  end

  // ==========================================================
  // Active settings load only on commit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      activeCfg <= '0;
    end else if (commitReq) begin
      activeCfg.filterOn <= merged[0][ncs_pkg::FILT_ON_B];
      activeCfg.coefZero <= {merged[0][6:0], merged[1][6:0]};
      activeCfg.coefOne  <= {merged[2][6:0], merged[3][6:0]};
    end
  end

  // Pulse marks the cycle the new settings appear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      commitPulse <= 1'b0;
    end else begin
      commitPulse <= commitReq;
    end
  end

  // ==========================================================
  // Pending flag: a notch register written since the last commit
  logic pending_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pending_reg <= 1'b0;
    end else if (commitReq) begin
      pending_reg <= 1'b0;
    end else if (|wrHit) begin
      pending_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Read data: staged words (bit 7 on NOTCH0 only) and pending flag, commit bit always reads zero
  logic [31:0] rdNext;

  always_comb begin
    rdNext = 32'h0000_0000;
    unique case (idx)
      ncs_pkg::IDX_NOTCH0: rdNext = {24'h000000, staged[0]};
      ncs_pkg::IDX_NOTCH1: rdNext = {25'h0000000, staged[1][6:0]};
      ncs_pkg::IDX_NOTCH2: rdNext = {25'h0000000, staged[2][6:0]};
      ncs_pkg::IDX_NOTCH3: rdNext = {25'h0000000, staged[3][6:0]};
      ncs_pkg::IDX_STATUS: rdNext = {31'h00000000, pending_reg};
      default:             rdNext = 32'h0000_0000;
    endcase
  end

  // Loaded at the edge that ends the wait cycle, so data stand at the handshake edge;
  // relies on the master holding the address for the whole request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
    end else if (accStart && read) begin
      readdata <= rdNext;
    end
  end

  // Unmapped read or write answers slave error
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      response <= ncs_pkg::BUS_OK;
    end else if (accStart) begin
      response <= mapped ? ncs_pkg::BUS_OK : ncs_pkg::BUS_SLVER;
    end
  end

endmodule

// ==== dv/ncs_notch_chk.sv ====
// Checker: commit timing and field placement of the notch bank
`timescale 1ns/1ps
module ncs_notch_chk (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_b,
  // Bus side
  input wire logic              read,
  input wire logic              write,
  input wire logic [9:0]        address,
  input wire logic [31:0]       writedata,
  input wire logic              waitrequest,
  input wire logic [31:0]       readdata,
  // Filter side
  input wire ncs_pkg::ncs_cfg_t activeCfg,
  input wire logic              commitPulse
);
  // ==========================================
  // Access decode, completing cycle only
  wire logic [7:0] ix  = address[9:2];
  wire logic       wr  = write & ~waitrequest;
  wire logic       wc  = wr & writedata[8];
  wire logic       hit = (ix >= 8'h1B) && (ix <= 8'h1E);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Commit and staging
  a_commit_pulse: assert property (wc && hit |=> commitPulse)
    else $error("commit write gave no pulse");
  a_stage_only: assert property (wr && !writedata[8] |=> !commitPulse)
    else $error("staging write committed");
  a_active_hold: assert property (!$stable(activeCfg) |-> commitPulse)
    else $error("active settings moved without commit");
  a_flag_unread: assert property (read && !waitrequest && hit
    |-> readdata[8] == 1'b0)
    else $error("commit flag read back");
  // Field placement, checked only where the write itself commits
  a_enable_high: assert property (wc && ix == 8'h1B |=>
    {activeCfg.filterOn, activeCfg.coefZero[13:7]} == $past(writedata[7:0]))
    else $error("enable or coef zero high misplaced");
  a_coef0_low: assert property (wc && ix == 8'h1C |=>
    activeCfg.coefZero[6:0] == $past(writedata[6:0]))
    else $error("coef zero low misplaced");
  a_coef1_high: assert property (wc && ix == 8'h1D |=>
    activeCfg.coefOne[13:7] == $past(writedata[6:0]))
    else $error("coef one high misplaced");
  a_coef1_low: assert property (wc && ix == 8'h1E |=>
    activeCfg.coefOne[6:0] == $past(writedata[6:0]))
    else $error("coef one low misplaced");
  // Main scenarios reached
  c_commit: cover property (commitPulse);
  c_stage: cover property (wr && !writedata[8] && hit);
  c_last: cover property (wc && ix == 8'h1E);
endmodule

// ==== dv/tb_ncs_notch_bank.sv ====
// Testbench: notch staging bank register and commit sequences
`timescale 1ns/1ps
module tb_ncs_notch_bank;
  // ==========================================
  // Design hookup
  logic              mclk, rst_b, read, write, waitrequest, commitPulse;
  logic [9:0]        address;
  logic [31:0]       writedata, readdata;
  logic [1:0]        response;
  ncs_pkg::ncs_cfg_t activeCfg, prev;
  logic [8:0]        v [4];
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  int                failures, compares;

  ncs_notch_bank i_ncs_notch_bank (.mclk, .rst_b, .read, .write, .address,
    .writedata, .waitrequest, .readdata, .response, .activeCfg,
    .commitPulse);

  // Compare and count
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One bus access, called just after a rising edge; request held until
  // waitrequest is sampled low, answer taken at that same edge
  task automatic acc(input logic w, input logic [7:0] ix,
                     input logic [8:0] d);
    int n;
    n = 0;
    write <= w;
    read <= ~w;
    address <= {ix, 2'b00};
    writedata <= {23'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rdata = readdata;
    rresp = response;
    ck(32'(n < 20), 32'h1);
    write <= 1'b0;
    read <= 1'b0;
    // Idle edge keeps two calls from driving in one time step
    @(posedge mclk);
  endtask

  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Free-running 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Hang guard, far beyond the roughly 110 cycles the tests need
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    // First request only at the edge after release
    @(posedge mclk);
    // Reset values of settings and registers
    ck(32'(activeCfg), 32'h0);
    for (int j = 0; j < 4; j++) begin
      acc(1'b0, 8'h1B + 8'(j), 9'h000);
      ck(rdata, 32'h0);
    end
    $display("test reset values done");
    // Stage three, commit through the fourth, each register in turn
    for (int k = 0; k < 4; k++) begin
      prev = activeCfg;
      for (int j = 0; j < 4; j++) v[j] = 9'((k * 37 + j * 19 + 65) % 256);
      for (int j = 0; j < 4; j++)
        if (j != k) acc(1'b1, 8'h1B + 8'(j), v[j]);
      ck(32'(activeCfg), 32'(prev));
      acc(1'b0, 8'h1F, 9'h000);
      ck(rdata, 32'h1);
      acc(1'b1, 8'h1B + 8'(k), v[k] | 9'h100);
      ck(32'(commitPulse), 32'h1);
      ck(32'(activeCfg), {3'h0, v[0][7:0], v[1][6:0], v[2][6:0],
        v[3][6:0]});
      acc(1'b0, 8'h1B + 8'(k), 9'h000);
      ck(rdata, {24'h0, k == 0 ? v[k][7] : 1'b0, v[k][6:0]});
      acc(1'b0, 8'h1F, 9'h000);
      ck(rdata, 32'h0);
      $display("test commit via register %0d done", k);
    end
    // Unmapped place: no commit, error response, zero data
    prev = activeCfg;
    acc(1'b1, 8'h05, 9'h1FF);
    ck(32'(commitPulse), 32'h0);
    acc(1'b0, 8'h05, 9'h000);
    ck(32'(rresp), 32'(ncs_pkg::BUS_SLVER));
    ck(rdata, 32'h0);
    ck(32'(activeCfg), 32'(prev));
    $display("test unmapped access done");
    stop_test();
  end
endmodule

bind ncs_notch_bank ncs_notch_chk i_ncs_notch_chk (.mclk, .rst_b, .read,
  .write, .address, .writedata, .waitrequest, .readdata, .activeCfg,
  .commitPulse);
